// File: rtci_pkg.sv
package rtci_pkg;
    localparam logic [7:0] ADDR_MIN_ALM = 8'h17;
    localparam logic [7:0] ADDR_HOUR_ALM = 8'h18;
    localparam logic [7:0] ADDR_DATE_ALM = 8'h19;
    localparam logic [7:0] ADDR_TMR_LO = 8'h1a;
    localparam logic [7:0] ADDR_TMR_HI = 8'h1b;
    localparam logic [7:0] ADDR_EXT = 8'h1c;
    localparam logic [7:0] ADDR_FLAG = 8'h1d;
    localparam logic [7:0] ADDR_CTRL = 8'h1e;
    localparam logic [7:0] EXT_RST = 8'h04;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ALM_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int ALM_MASK = 7;
    localparam int EXT_UPD_SEL = 5;
    localparam int EXT_RUN = 4;
    localparam int EXT_DAY_SEL = 3;
    localparam int EXT_TSEL_HI = 2;
    localparam int FLAG_UPD = 5;
    localparam int FLAG_TF = 4;
    localparam int FLAG_ALM = 3;
    localparam int CTRL_STOP = 6;
    localparam int CTRL_UPD_IE = 5;
    localparam int CTRL_TIE = 4;
    localparam int CTRL_ALM_IE = 3;
    localparam int CTRL_PAUSE = 2;
    localparam int CTRL_TBKON = 1;
    localparam int CTRL_BK_SEL = 0;
    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
    localparam int UPD_REL_MIN_US = 7570;
    localparam int UPD_REL_MAX_US = 15630;
    localparam int TRTN2_FAST_US = 122;
    localparam int ALARM_DELAY_MAX_US = 1460;
    localparam int UPD_REL_CYC = (UPD_REL_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UPD_REL_MAX_CYC = (UPD_REL_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int TRTN2_FAST_CYC = (TRTN2_FAST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ALARM_DELAY_CYC = (ALARM_DELAY_MAX_US * 1000) / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        SRC_4096 = 3'b000,
        SRC_64 = 3'b001,
        SRC_1HZ = 3'b010,
        SRC_MIN = 3'b011,
        SRC_HOUR = 3'b100
    } rtci_src_t;
    typedef enum logic {
        PUL_IDLE = 1'b0,
        PUL_LOW = 1'b1
    } rtci_pulse_t;
endpackage

// File: rtci_cnt_if.sv
interface rtci_cnt_if;
    import rtci_pkg::*;
    logic run;
    logic pause;
    logic halt;
    logic bk_sel;
    logic bk_on;
    logic on_backup;
    rtci_src_t src;
    logic tick_4096;
    logic tick_64;
    logic tick_1hz;
    logic tick_min;
    logic tick_hour;
    logic [TMR_W-1:0] preset;
    logic [TMR_W-1:0] count;
    logic expired;
    modport ctl (output run, pause, halt, bk_sel, bk_on, on_backup, src, tick_4096, tick_64, tick_1hz,
        tick_min, tick_hour, preset, input count, expired);
    modport cnt (input run, pause, halt, bk_sel, bk_on, on_backup, src, tick_4096, tick_64, tick_1hz,
        tick_min, tick_hour, preset, output count, expired);
endinterface

// File: rtci_countdown.sv
module rtci_countdown (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    rtci_cnt_if.cnt cif
);
    import rtci_pkg::*;
    logic src_tick;
    logic stop;
    always_comb
    begin
        case (cif.src)
            SRC_4096: src_tick = cif.tick_4096;
            SRC_64: src_tick = cif.tick_64;
            SRC_1HZ: src_tick = cif.tick_1hz;
            SRC_MIN: src_tick = cif.tick_min;
            SRC_HOUR: src_tick = cif.tick_hour;
            default: src_tick = 1'b0;
        endcase
    end
    assign stop = (cif.pause && !cif.bk_sel)
        || (cif.halt && cif.src != SRC_4096)
        || (cif.bk_sel && (cif.on_backup != cif.bk_on));
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cif.count <= TMR_RST;
            cif.expired <= 1'b0;
        end
        else if (ce)
        begin
            cif.expired <= 1'b0;
            if (!cif.run)
                cif.count <= cif.preset;
            else if (src_tick && !stop && cif.count != TMR_RST)
            begin
                if (cif.count == TMR_ONE)
                begin
                    cif.count <= cif.preset;
                    cif.expired <= 1'b1;
                end
                else
                    cif.count <= cif.count - TMR_ONE;
            end
        end
    end
    AST_RUN_OFF_LOAD: assert property (@(posedge clk) disable iff (!resetn)
        ce && !cif.run |=> cif.count == $past(cif.preset))
        else $error("stopped countdown did not load the preset");
    AST_PAUSE_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
        ce && cif.run && cif.pause && !cif.bk_sel |=> cif.count == $past(cif.count))
        else $error("paused countdown moved");
endmodule

// File: rtci_alarm_match.sv
module rtci_alarm_match (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] minute_alarm_match,
    input wire logic [7:0] hour_alarm_match,
    input wire logic [7:0] date_alarm_match,
    input wire logic weekday_date_select,
    input wire logic [6:0] cur_minute,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_weekday,
    input wire logic [5:0] cur_date,
    input wire logic min_tick,
    input wire logic halt,
    output logic hit
);
    import rtci_pkg::*;
    logic min_ok;
    logic hour_ok;
    logic day_ok;
    assign min_ok = minute_alarm_match[ALM_MASK] || minute_alarm_match[6:0] == cur_minute;
    assign hour_ok = hour_alarm_match[ALM_MASK] || hour_alarm_match[5:0] == cur_hour;
    assign day_ok = date_alarm_match[ALM_MASK]
        || (weekday_date_select ? date_alarm_match[5:0] == cur_date
        : (date_alarm_match[6:0] & cur_weekday) != 7'h00);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            hit <= 1'b0;
        else if (ce)
            hit <= min_tick && !halt && min_ok && hour_ok && day_ok;
    end
endmodule

// File: rtci_irq_events.sv
module rtci_irq_events #(
    parameter int UPD_RELEASE_CYC = rtci_pkg::UPD_REL_CYC,
    parameter int TMR_FAST_RELEASE_CYC = rtci_pkg::TRTN2_FAST_CYC,
    parameter int TMR_SLOW_RELEASE_CYC = rtci_pkg::UPD_REL_CYC,
    parameter int REL_W = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic tick_4096,
    input wire logic tick_64,
    input wire logic sec_tick,
    input wire logic min_tick,
    input wire logic hour_tick,
    input wire logic on_backup,
    input wire logic [6:0] cur_minute,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_weekday,
    input wire logic [5:0] cur_date,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_n_oe,
    output logic calendar_halt
);
    import rtci_pkg::*;

    if (UPD_RELEASE_CYC < 1 || UPD_RELEASE_CYC >= (1 << REL_W) || TMR_FAST_RELEASE_CYC < 1
        || TMR_FAST_RELEASE_CYC >= (1 << REL_W) || TMR_SLOW_RELEASE_CYC < 1
        || TMR_SLOW_RELEASE_CYC >= (1 << REL_W) || REL_W > 31)
    begin : g_bad_param
        $error("release counts do not fit the release counter");
    end

    localparam logic [REL_W-1:0] REL_ONE = REL_W'(1);
    localparam logic [REL_W-1:0] UPD_LAST = REL_W'(UPD_RELEASE_CYC - 1);
    localparam logic [REL_W-1:0] TMR_FAST_LAST = REL_W'(TMR_FAST_RELEASE_CYC - 1);
    localparam logic [REL_W-1:0] TMR_SLOW_LAST = REL_W'(TMR_SLOW_RELEASE_CYC - 1);

    logic [7:0] minute_alarm_match;
    logic [7:0] hour_alarm_match;
    logic [7:0] date_alarm_match;
    logic [TMR_W-1:0] timer_preset;
    logic [7:0] extension_settings;
    logic [7:0] interrupt_control;
    logic update_event_flag;
    logic timer_event_flag;
    logic alarm_event_flag;
    logic alarm_req;
    rtci_pulse_t upd_state;
    rtci_pulse_t tmr_state;
    logic [REL_W-1:0] upd_cnt;
    logic [REL_W-1:0] tmr_cnt;
    logic [REL_W-1:0] tmr_last;
    logic flag_wr;
    logic upd_evt;
    logic alm_hit;
    logic halt;
    logic update_period_select;
    logic countdown_run;
    logic weekday_date_select;
    logic update_irq_enable;
    logic timer_irq_enable;
    logic alarm_irq_enable;
    logic next_irq_oe;
    rtci_cnt_if cif ();

    assign halt = interrupt_control[CTRL_STOP];
    assign update_period_select = extension_settings[EXT_UPD_SEL];
    assign countdown_run = extension_settings[EXT_RUN];
    assign weekday_date_select = extension_settings[EXT_DAY_SEL];
    assign update_irq_enable = interrupt_control[CTRL_UPD_IE];
    assign timer_irq_enable = interrupt_control[CTRL_TIE];
    assign alarm_irq_enable = interrupt_control[CTRL_ALM_IE];
    assign calendar_halt = interrupt_control[CTRL_STOP];
    assign flag_wr = ce && reg_wr && reg_addr == ADDR_FLAG;

    // Update boundary chosen by the period select; no events while halted
    assign upd_evt = (update_period_select ? min_tick : sec_tick) && !halt;

    assign cif.run = countdown_run;
    assign cif.pause = interrupt_control[CTRL_PAUSE];
    assign cif.halt = halt;
    assign cif.bk_sel = interrupt_control[CTRL_BK_SEL];
    assign cif.bk_on = interrupt_control[CTRL_TBKON];
    assign cif.on_backup = on_backup;
    assign cif.src = rtci_src_t'(extension_settings[EXT_TSEL_HI:0]);
    assign cif.tick_4096 = tick_4096;
    assign cif.tick_64 = tick_64;
    assign cif.tick_1hz = sec_tick;
    assign cif.tick_min = min_tick;
    assign cif.tick_hour = hour_tick;
    assign cif.preset = timer_preset;

    rtci_countdown u_countdown (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .cif(cif)
    );

    rtci_alarm_match u_alarm (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .minute_alarm_match(minute_alarm_match),
        .hour_alarm_match(hour_alarm_match),
        .date_alarm_match(date_alarm_match),
        .weekday_date_select(weekday_date_select),
        .cur_minute(cur_minute),
        .cur_hour(cur_hour),
        .cur_weekday(cur_weekday),
        .cur_date(cur_date),
        .min_tick(min_tick),
        .halt(halt),
        .hit(alm_hit)
    );

    // Settings registers; the weekday and date alarm share one byte
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            minute_alarm_match <= ALM_RST;
            hour_alarm_match <= ALM_RST;
            date_alarm_match <= ALM_RST;
            timer_preset <= TMR_RST;
            extension_settings <= EXT_RST;
            interrupt_control <= CTRL_RST;
        end
        else if (ce && reg_wr)
        begin
            case (reg_addr)
                ADDR_MIN_ALM: minute_alarm_match <= reg_wdata;
                ADDR_HOUR_ALM: hour_alarm_match <= reg_wdata;
                ADDR_DATE_ALM: date_alarm_match <= reg_wdata;
                ADDR_TMR_LO: timer_preset[7:0] <= reg_wdata;
                ADDR_TMR_HI: timer_preset[TMR_W-1:8] <= reg_wdata;
                ADDR_EXT: extension_settings <= reg_wdata;
                ADDR_CTRL: interrupt_control <= reg_wdata;
                default: interrupt_control <= interrupt_control;
            endcase
        end
    end

    // Sticky flags: the hardware set wins over a clear written in the same cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            update_event_flag <= 1'b0;
            timer_event_flag <= 1'b0;
            alarm_event_flag <= 1'b0;
        end
        else if (ce)
        begin
            if (upd_evt)
                update_event_flag <= 1'b1;
            else if (flag_wr && !reg_wdata[FLAG_UPD])
                update_event_flag <= 1'b0;
            if (cif.expired)
                timer_event_flag <= 1'b1;
            else if (flag_wr && !reg_wdata[FLAG_TF])
                timer_event_flag <= 1'b0;
            if (alm_hit)
                alarm_event_flag <= 1'b1;
            else if (flag_wr && !reg_wdata[FLAG_ALM])
                alarm_event_flag <= 1'b0;
        end
    end

    // Alarm low has no automatic release; flag clear or enable drop cancels it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            alarm_req <= 1'b0;
        else if (ce)
        begin
            if (alm_hit && alarm_irq_enable)
                alarm_req <= 1'b1;
            else if (!alarm_irq_enable || (flag_wr && !reg_wdata[FLAG_ALM]))
                alarm_req <= 1'b0;
        end
    end

    // Update low: fixed release time, restarted by each event, not tied to the flag
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            upd_state <= PUL_IDLE;
            upd_cnt <= '0;
        end
        else if (ce)
        begin
            case (upd_state)
                PUL_IDLE:
                begin
                    upd_cnt <= '0;
                    if (upd_evt && update_irq_enable)
                        upd_state <= PUL_LOW;
                end
                PUL_LOW:
                begin
                    if (!update_irq_enable)
                        upd_state <= PUL_IDLE;
                    else if (upd_evt)
                        upd_cnt <= '0;
                    else if (upd_cnt == UPD_LAST)
                        upd_state <= PUL_IDLE;
                    else
                        upd_cnt <= upd_cnt + REL_ONE;
                end
                default: upd_state <= PUL_IDLE;
            endcase
        end
    end

    // Wakeup low: release time depends on the source, fastest source is shorter
    assign tmr_last = cif.src == SRC_4096 ? TMR_FAST_LAST : TMR_SLOW_LAST;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tmr_state <= PUL_IDLE;
            tmr_cnt <= '0;
        end
        else if (ce)
        begin
            case (tmr_state)
                PUL_IDLE:
                begin
                    tmr_cnt <= '0;
                    if (cif.expired && timer_irq_enable)
                        tmr_state <= PUL_LOW;
                end
                PUL_LOW:
                begin
                    if (!timer_irq_enable || !countdown_run || (flag_wr && !reg_wdata[FLAG_TF]))
                        tmr_state <= PUL_IDLE;
                    else if (cif.expired)
                        tmr_cnt <= '0;
                    else if (tmr_cnt >= tmr_last)
                        tmr_state <= PUL_IDLE;
                    else
                        tmr_cnt <= tmr_cnt + REL_ONE;
                end
                default: tmr_state <= PUL_IDLE;
            endcase
        end
    end

    // Open-drain pin: only ever pulls low, so the data flop is a constant zero
    assign next_irq_oe = alarm_req || upd_state == PUL_LOW || tmr_state == PUL_LOW;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_n_oe <= 1'b0;
            irq_n_o <= 1'b0;
        end
        else if (ce)
        begin
            irq_n_oe <= next_irq_oe;
            irq_n_o <= 1'b0;
        end
    end

    // Read port; the count reads live only while running, so software reads twice
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= BYTE_ZERO;
        else if (ce && reg_rd)
        begin
            case (reg_addr)
                ADDR_MIN_ALM: reg_rdata <= minute_alarm_match;
                ADDR_HOUR_ALM: reg_rdata <= hour_alarm_match;
                ADDR_DATE_ALM: reg_rdata <= date_alarm_match;
                ADDR_TMR_LO: reg_rdata <= countdown_run ? cif.count[7:0] : timer_preset[7:0];
                ADDR_TMR_HI: reg_rdata <= countdown_run ? cif.count[TMR_W-1:8] : timer_preset[TMR_W-1:8];
                ADDR_EXT: reg_rdata <= extension_settings;
                ADDR_FLAG:
                begin
                    reg_rdata <= BYTE_ZERO;
                    reg_rdata[FLAG_UPD] <= update_event_flag;
                    reg_rdata[FLAG_TF] <= timer_event_flag;
                    reg_rdata[FLAG_ALM] <= alarm_event_flag;
                end
                ADDR_CTRL: reg_rdata <= interrupt_control;
                default: reg_rdata <= BYTE_ZERO;
            endcase
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_update_event;
        ce && upd_evt;
    endsequence
    sequence s_alarm_event;
        ce && alm_hit && alarm_irq_enable;
    endsequence

    AST_UPD_FLAG_SET: assert property (s_update_event |=> update_event_flag)
        else $error("update event did not set its flag");
    AST_UPD_LOW: assert property (s_update_event ##0 update_irq_enable |=> upd_state == PUL_LOW)
        else $error("enabled update event did not pull low");
    AST_UPD_QUIET: assert property (s_update_event ##0 !update_irq_enable && upd_state == PUL_IDLE
        |=> upd_state == PUL_IDLE)
        else $error("disabled update event pulled low");
    AST_UPD_WIDTH: assert property ($fell(upd_state == PUL_LOW) && $past(update_irq_enable)
        |-> $past(upd_cnt) == UPD_LAST)
        else $error("update low released at the wrong time");
    AST_UPD_MAX: assert property (upd_cnt <= REL_W'(UPD_REL_MAX_CYC))
        else $error("update low exceeded its longest time");
    AST_UPD_CLEAR_KEEPS: assert property (upd_state == PUL_LOW && flag_wr && !reg_wdata[FLAG_UPD]
        && update_irq_enable && upd_cnt != UPD_LAST |=> upd_state == PUL_LOW)
        else $error("flag clear changed the update low");
    AST_UPD_EN_DROP: assert property (ce && !update_irq_enable |=> upd_state == PUL_IDLE)
        else $error("update low kept after enable dropped");
    AST_HALT_NO_EVT: assert property (halt |-> !upd_evt ##1 !(ce && alm_hit && $past(halt)))
        else $error("event while calendar halted");
    AST_ALARM_IRQ: assert property (s_alarm_event |-> ##[1:2] irq_n_oe && alarm_event_flag)
        else $error("alarm did not assert the interrupt");
    AST_ALM_FLAG_STICKY: assert property (ce && alarm_event_flag && !(flag_wr && !reg_wdata[FLAG_ALM])
        |=> alarm_event_flag)
        else $error("alarm flag lost without a zero write");
    AST_ALM_EN_GATES: assert property (ce && !alarm_irq_enable |=> !alarm_req)
        else $error("alarm low kept with enable off");
    AST_PIN_FOLLOWS: assert property (ce |=> irq_n_oe == $past(next_irq_oe) && !irq_n_o)
        else $error("interrupt pin does not follow the requests");
endmodule

// File: rtci_host_model.sv
module rtci_host_model (
    input wire logic clk,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import rtci_pkg::*;
    // Strobes are held over one rising edge only, so a write is never taken twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        wr(ADDR_CTRL, CTRL_RST);
        wr(a, d);
    endtask
endmodule

// File: test_rtci_irq_events.sv
module test_rtci_irq_events;
    timeunit 1ns;
    timeprecision 1ps;
    import rtci_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] ticks = 5'h00;
    logic on_backup = 1'b0;
    logic [6:0] cur_minute = 7'h00;
    logic [5:0] cur_hour = 6'h00;
    logic [6:0] cur_weekday = 7'h01;
    logic [5:0] cur_date = 6'h01;
    logic reg_wr, reg_rd, irq_n_o, irq_n_oe, cal_halt;
    logic ce = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    int num_errors = 0;
    int total_checks = 0;
    int cnt = 5;
    int m, d;
    always #10 clk = ~clk;
    rtci_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    rtci_irq_events #(.UPD_RELEASE_CYC(20), .TMR_FAST_RELEASE_CYC(5), .TMR_SLOW_RELEASE_CYC(20)) dut_u (
        .clk(clk), .resetn(resetn), .ce(ce), .tick_4096(ticks[0]), .tick_64(ticks[1]), .sec_tick(ticks[2]),
        .min_tick(ticks[3]), .hour_tick(ticks[4]), .on_backup(on_backup), .cur_minute(cur_minute),
        .cur_hour(cur_hour), .cur_weekday(cur_weekday), .cur_date(cur_date), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_n_i(irq_n_oe ? irq_n_o : 1'b1),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .calendar_halt(cal_halt));
    function automatic logic [6:0] bcd(input int v);
        return 7'(((v / 10) << 4) | (v % 10));
    endfunction
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic pulse(input int b);
        @(negedge clk);
        ticks[b] = 1'b1;
        @(negedge clk);
        ticks[b] = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic flags(input logic [7:0] e);
        host_u.rd(ADDR_FLAG, rv);
        chk("flags", rv, e);
    endtask
    task automatic alm(input logic [7:0] mn, dy, x, ct, input logic [6:0] cm, wd, input logic e, rel);
        host_u.cfg(ADDR_MIN_ALM, mn);
        host_u.wr(ADDR_HOUR_ALM, 8'h80);
        host_u.wr(ADDR_DATE_ALM, dy);
        host_u.wr(ADDR_EXT, x);
        host_u.wr(ADDR_FLAG, BYTE_ZERO);
        host_u.wr(ADDR_CTRL, ct);
        cur_minute = cm;
        cur_weekday = wd;
        pulse(3);
        flags({4'h0, e, 3'h0});
        host_u.wr(ADDR_FLAG, 8'h08);
        chk("alarm pin", {7'h0, irq_n_oe}, {7'h0, e});
        chk("pin data", {7'h0, irq_n_o}, 8'h00);
        host_u.wr(rel ? ADDR_FLAG : ADDR_CTRL, 8'h00);
        repeat (2) @(negedge clk);
        chk("alarm off", {7'h0, irq_n_oe}, 8'h00);
        flags({4'h0, e & !rel, 3'h0});
    endtask
    // Count model: per tick, in the source selected, unless paused, backup-gated, or halted with a source other than 4096 Hz
    task automatic step(input logic [7:0] ct, x, input int b, n);
        host_u.wr(ADDR_CTRL, ct);
        host_u.wr(ADDR_EXT, x);
        repeat (n)
        begin
            pulse(b);
            if (x[EXT_RUN] && b == int'(x[2:0]) && (!ct[CTRL_STOP] || b == 0)
                && (ct[CTRL_BK_SEL] ? on_backup == ct[CTRL_TBKON] : !ct[CTRL_PAUSE]))
                cnt = (cnt == 1) ? 5 : cnt - 1;
        end
        if (!x[EXT_RUN])
            cnt = 5;
        host_u.rd(ADDR_TMR_LO, rv);
        chk("count", rv, 8'(cnt));
    endtask
    task automatic end_of_test();
        $display("Checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #(20ns * 20000);
        num_errors++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'he2f7));
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        host_u.rd(8'h1f, rv);
        chk("unmapped", rv, 8'h00);
        host_u.rd(ADDR_EXT, rv);
        chk("ext reset", rv, EXT_RST);
        host_u.rd(ADDR_CTRL, rv);
        chk("ctrl reset", rv, CTRL_RST);
        ce = 1'b0;
        pulse(2);
        ce = 1'b1;
        flags(8'h00);
        $display("Test reset done");
        host_u.cfg(ADDR_EXT, 8'h04);
        host_u.wr(ADDR_CTRL, 8'h20);
        pulse(3);
        flags(8'h00);
        pulse(2);
        chk("upd pin", {7'h0, irq_n_oe}, 8'h01);
        flags(8'h20);
        host_u.wr(ADDR_FLAG, BYTE_ZERO);
        chk("upd hold", {7'h0, irq_n_oe}, 8'h01);
        repeat (20) @(negedge clk);
        chk("upd rel", {7'h0, irq_n_oe}, 8'h00);
        pulse(2);
        host_u.wr(ADDR_CTRL, 8'h00);
        repeat (2) @(negedge clk);
        chk("upd disable", {7'h0, irq_n_oe}, 8'h00);
        pulse(2);
        chk("upd off", {7'h0, irq_n_oe}, 8'h00);
        host_u.wr(ADDR_EXT, 8'h24);
        host_u.wr(ADDR_FLAG, BYTE_ZERO);
        pulse(2);
        flags(8'h00);
        pulse(3);
        flags(8'h20);
        host_u.wr(ADDR_FLAG, BYTE_ZERO);
        host_u.wr(ADDR_CTRL, 8'h40);
        chk("halt", {7'h0, cal_halt}, 8'h01);
        pulse(3);
        flags(8'h00);
        $display("Test update done");
        m = $urandom_range(59);
        d = $urandom_range(28, 1);
        cur_hour = 6'(bcd($urandom_range(23)));
        cur_date = 6'(bcd(d));
        alm(8'h80, 8'h80, 8'h00, 8'h08, bcd(m), 7'h01, 1'b1, 1'b0);
        alm({1'b0, bcd(m)}, 8'h80, 8'h00, 8'h08, bcd(m), 7'h01, 1'b1, 1'b1);
        alm({1'b0, bcd(m)}, 8'h80, 8'h00, 8'h08, bcd((m + 1) % 60), 7'h01, 1'b0, 1'b1);
        alm(8'h80, 8'h2a, 8'h00, 8'h08, bcd(m), 7'h08, 1'b1, 1'b1);
        alm(8'h80, 8'h2a, 8'h00, 8'h08, bcd(m), 7'h04, 1'b0, 1'b1);
        alm(8'h80, {1'b0, bcd(d)}, 8'h08, 8'h08, bcd(m), 7'h01, 1'b1, 1'b1);
        alm(8'h80, 8'h80, 8'h00, 8'h48, bcd(m), 7'h01, 1'b0, 1'b1);
        $display("Test alarm done");
        host_u.cfg(ADDR_TMR_LO, 8'h05);
        host_u.wr(ADDR_TMR_HI, 8'h00);
        step(8'h00, 8'h10, 0, 2);
        step(8'h04, 8'h10, 0, 2);
        step(8'h05, 8'h10, 0, 2);
        step(8'h40, 8'h10, 0, 1);
        flags(8'h10);
        step(8'h40, 8'h11, 1, 2);
        step(8'h00, 8'h11, 2, 1);
        step(8'h00, 8'h12, 2, 2);
        step(8'h00, 8'h13, 3, 1);
        step(8'h00, 8'h14, 4, 1);
        step(8'h00, 8'h00, 0, 0);
        step(8'h10, 8'h10, 0, 5);
        chk("tmr pin", {7'h0, irq_n_oe}, 8'h01);
        repeat (3) @(negedge clk);
        chk("tmr rel", {7'h0, irq_n_oe}, 8'h00);
        $display("Test countdown done");
        end_of_test();
    end
endmodule
